// ---- shared/mlaic_pkg.sv ----
// constants, offsets and types for the interrupt combiner
package mlaic_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_SLOTS = 2;
   localparam int PHY_COUNT = 32;
   localparam int TX_CH = 8;
   localparam int RX_CH = 8;
   localparam logic [ADDR_W-1:0] OFS_WRAPPER_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_IRQ_PACE_COUNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TRANSFER_PRIORITY = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CAUSE_VECTOR = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_MONITOR_SELECT_SLOT0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MONITOR_SELECT_SLOT1 = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_LINK_EVENT_RAW = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_LINK_EVENT_MASKED = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_COMPLETION_RAW = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_COMPLETION_MASKED = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_COMPLETION_MASK_SET = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_COMPLETION_MASK_CLEAR = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATE = 8'h30;
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_MAC_RST_BIT = 1;
   localparam int CTL_MGMT_RST_BIT = 2;
   localparam int CTL_W = 3;
   localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;
   localparam int PACE_W = 16;
   localparam logic [PACE_W-1:0] PACE_RESET = 16'h0000;
   localparam int PRIO_W = 8;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 8'h00;
   localparam int SEL_ADDR_W = 5;
   localparam int SEL_ENB_BIT = 8;
   localparam int SEL_W = 9;
   localparam logic [SEL_W-1:0] SEL_RESET = 9'h000;
   localparam logic [NUM_SLOTS-1:0] CMASK_RESET = 2'h0;
   localparam int CAUSE_TX_LSB = 0;
   localparam int CAUSE_RX_LSB = 8;
   localparam int CAUSE_STAT_BIT = 16;
   localparam int CAUSE_HOST_BIT = 17;
   localparam int CAUSE_LINK_BIT = 18;
   localparam int CAUSE_USER_BIT = 19;
   localparam int STATE_IRQ_BIT = 0;
   localparam int STATE_PACING_BIT = 1;
   localparam int STATE_CNT_LSB = 16;
   typedef enum logic [1:0] {
      MLAIC_IDLE,
      MLAIC_ASSERTED,
      MLAIC_PACING
   } mlaic_pace_e;
endpackage : mlaic_pkg

// ---- shared/mlaic_slot_if.sv ----
// signals between the combiner and one event slot
`timescale 1ns/10ps
interface mlaic_slot_if;
   logic event_in;
   logic enable;
   logic clr;
   logic hold_clr;
   logic raw;
   logic masked;
   modport ctrl (output event_in, output enable, output clr, output hold_clr,
      input raw, input masked);
   modport slot (input event_in, input enable, input clr, input hold_clr,
      output raw, output masked);
endinterface : mlaic_slot_if

// ---- core/mlaic_event_slot.sv ----
// one sticky raw/masked event bit pair with write-one-to-clear
`timescale 1ns/10ps
module mlaic_event_slot
   import mlaic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   mlaic_slot_if.slot sif
);
   logic set;
   assign set = sif.event_in & ~sif.hold_clr;

   // set beats clear so an event in the clearing cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sif.raw <= 1'b0;
      end else if (sif.hold_clr) begin
         sif.raw <= 1'b0;
      end else begin
         sif.raw <= (sif.raw & ~sif.clr) | set;
      end
   end

   // masked copy only follows events seen while enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sif.masked <= 1'b0;
      end else if (sif.hold_clr) begin
         sif.masked <= 1'b0;
      end else begin
         sif.masked <= (sif.masked & ~sif.clr) | (set & sif.enable);
      end
   end
endmodule : mlaic_event_slot

// ---- core/mlaic_combiner.sv ----
// interrupt combiner for link, access completion and mac sources
//
// Functional notes
// - all mac and management sources merge into one interrupt output
// - readable cause vector: tx, rx, statistics, host, link, access done
// - link change irq on slot phy link change while slot enable set
// - raw link event bit 0 is slot 0, bit 1 is slot 1
// - enabled link event also sets masked bit; writing one clears it
// - access done irq when go falls and completion mask bit set
// - raw completion bit 0 is access slot 0, bit 1 slot 1
// - enabled completion also sets masked bit; writing one clears it
// - management irqs are levels held while cause pending and uncleared
// - enable off then on with active source gives a new rising edge
// - pacing counts programmed peripheral clock cycles between interrupts
// - disable then re-enable resets the pace counter
// - control holds global enable, mac reset and management reset
// - register sets transfer priority of mac memory accesses
// - completed access clears go and sets raw completion bit; here go is an input, and its fall sets the raw bit
// - monitored link change sets raw and masked bits per slot enable
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module mlaic_combiner
   import mlaic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [TX_CH-1:0] tx_channel_pending,
   input wire logic [RX_CH-1:0] rx_channel_pending,
   input wire logic statistics_pending,
   input wire logic host_error_pending,
   input wire logic [PHY_COUNT-1:0] phy_link_status,
   input wire logic [NUM_SLOTS-1:0] access_go,
   output logic irq_out,
   output logic link_change_irq,
   output logic access_done_irq,
   output logic mac_reset,
   output logic mgmt_unit_reset,
   output logic [PRIO_W-1:0] transfer_priority_control
);
   logic [CTL_W-1:0] wrapper_control_q;
   logic [PACE_W-1:0] irq_pace_count_q;
   logic [PRIO_W-1:0] prio_q;
   logic [SEL_W-1:0] monitor_select_slot_q [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] cmask_q;
   logic [NUM_SLOTS-1:0] link_prev_q;
   logic [SEL_ADDR_W-1:0] addr_prev_q [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] go_prev_q;
   logic [NUM_SLOTS-1:0] link_now;
   logic [NUM_SLOTS-1:0] link_change;
   logic [NUM_SLOTS-1:0] go_fall;
   logic [NUM_SLOTS-1:0] link_raw;
   logic [NUM_SLOTS-1:0] link_masked;
   logic [NUM_SLOTS-1:0] comp_raw;
   logic [NUM_SLOTS-1:0] comp_masked;
   logic [NUM_SLOTS-1:0] link_clr;
   logic [NUM_SLOTS-1:0] comp_clr;
   logic [DATA_W-1:0] irq_cause_vector;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] prdata_q;
   logic err_d;
   logic err_q;
   logic wr_en;
   logic setup;
   logic global_irq_enable;
   logic en_prev_q;
   logic en_rise;
   logic any_active;
   mlaic_pace_e state_q;
   logic [PACE_W-1:0] pace_cnt_q;
   logic irq_q;

   assign wr_en = psel & penable & pwrite;
   assign setup = psel & ~penable;
   assign global_irq_enable = wrapper_control_q[CTL_EN_BIT];
   assign mac_reset = wrapper_control_q[CTL_MAC_RST_BIT];
   assign mgmt_unit_reset = wrapper_control_q[CTL_MGMT_RST_BIT];
   assign transfer_priority_control = prio_q;

   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrapper_control_q <= CTL_RESET;
      end else if (wr_en && paddr == OFS_WRAPPER_CONTROL) begin
         wrapper_control_q <= pwdata[CTL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pace_count_q <= PACE_RESET;
      end else if (wr_en && paddr == OFS_IRQ_PACE_COUNT) begin
         irq_pace_count_q <= pwdata[PACE_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_q <= PRIO_RESET;
      end else if (wr_en && paddr == OFS_TRANSFER_PRIORITY) begin
         prio_q <= pwdata[PRIO_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor_select_slot_q[0] <= SEL_RESET;
         monitor_select_slot_q[1] <= SEL_RESET;
      end else if (wr_en && paddr == OFS_MONITOR_SELECT_SLOT0) begin
         monitor_select_slot_q[0] <= pwdata[SEL_W-1:0];
      end else if (wr_en && paddr == OFS_MONITOR_SELECT_SLOT1) begin
         monitor_select_slot_q[1] <= pwdata[SEL_W-1:0];
      end
   end

   // mask set and clear registers share one mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmask_q <= CMASK_RESET;
      end else if (wr_en && paddr == OFS_COMPLETION_MASK_SET) begin
         cmask_q <= cmask_q | pwdata[NUM_SLOTS-1:0];
      end else if (wr_en && paddr == OFS_COMPLETION_MASK_CLEAR) begin
         cmask_q <= cmask_q & ~pwdata[NUM_SLOTS-1:0];
      end
   end

   // event detection; the address is compared too so that retargeting a
   // slot does not look like a link change
   always_comb begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
         link_now[i] = phy_link_status[monitor_select_slot_q[i][SEL_ADDR_W-1:0]];
         link_change[i] = (link_now[i] != link_prev_q[i]) &&
            (monitor_select_slot_q[i][SEL_ADDR_W-1:0] == addr_prev_q[i]);
         go_fall[i] = go_prev_q[i] & ~access_go[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_prev_q <= '0;
         go_prev_q <= '0;
         addr_prev_q[0] <= '0;
         addr_prev_q[1] <= '0;
      end else begin
         link_prev_q <= link_now;
         go_prev_q <= access_go;
         addr_prev_q[0] <= monitor_select_slot_q[0][SEL_ADDR_W-1:0];
         addr_prev_q[1] <= monitor_select_slot_q[1][SEL_ADDR_W-1:0];
      end
   end

   // writing one to a bit of either raw or masked view clears both views
   always_comb begin
      link_clr = '0;
      comp_clr = '0;
      if (wr_en && (paddr == OFS_LINK_EVENT_RAW || paddr == OFS_LINK_EVENT_MASKED)) begin
         link_clr = pwdata[NUM_SLOTS-1:0];
      end
      if (wr_en && (paddr == OFS_COMPLETION_RAW || paddr == OFS_COMPLETION_MASKED)) begin
         comp_clr = pwdata[NUM_SLOTS-1:0];
      end
   end

   // slots 0..1 hold link events, slots 2..3 hold access completions
   mlaic_slot_if slot_if [2*NUM_SLOTS] ();

   for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
      assign slot_if[g].event_in = link_change[g];
      assign slot_if[g].enable = monitor_select_slot_q[g][SEL_ENB_BIT];
      assign slot_if[g].clr = link_clr[g];
      assign slot_if[g].hold_clr = mgmt_unit_reset;
      assign link_raw[g] = slot_if[g].raw;
      assign link_masked[g] = slot_if[g].masked;
      assign slot_if[g+NUM_SLOTS].event_in = go_fall[g];
      assign slot_if[g+NUM_SLOTS].enable = cmask_q[g];
      assign slot_if[g+NUM_SLOTS].clr = comp_clr[g];
      assign slot_if[g+NUM_SLOTS].hold_clr = mgmt_unit_reset;
      assign comp_raw[g] = slot_if[g+NUM_SLOTS].raw;
      assign comp_masked[g] = slot_if[g+NUM_SLOTS].masked;
      mlaic_event_slot u_link (
         .pclk(pclk),
         .presetn(presetn),
         .sif(slot_if[g])
      );
      mlaic_event_slot u_comp (
         .pclk(pclk),
         .presetn(presetn),
         .sif(slot_if[g+NUM_SLOTS])
      );
   end

   // levels straight from the sticky masked bits
   assign link_change_irq = |link_masked;
   assign access_done_irq = |comp_masked;

   // mac sources are gated while the mac is held in reset
   always_comb begin
      irq_cause_vector = '0;
      if (!mac_reset) begin
         irq_cause_vector[CAUSE_TX_LSB +: TX_CH] = tx_channel_pending;
         irq_cause_vector[CAUSE_RX_LSB +: RX_CH] = rx_channel_pending;
         irq_cause_vector[CAUSE_STAT_BIT] = statistics_pending;
         irq_cause_vector[CAUSE_HOST_BIT] = host_error_pending;
      end
      irq_cause_vector[CAUSE_LINK_BIT] = link_change_irq;
      irq_cause_vector[CAUSE_USER_BIT] = access_done_irq;
   end

   assign any_active = |irq_cause_vector;
   assign en_rise = global_irq_enable & ~en_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= global_irq_enable;
      end
   end

   // pacing: output rises only from idle; after it falls the counter must
   // run out first. pclk is the peripheral clock, so one count is one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= MLAIC_IDLE;
      end else if (en_rise) begin
         state_q <= MLAIC_IDLE;
      end else begin
         case (state_q)
            MLAIC_IDLE: begin
               if (global_irq_enable && any_active) begin
                  state_q <= MLAIC_ASSERTED;
               end
            end
            MLAIC_ASSERTED: begin
               if (!(global_irq_enable && any_active)) begin
                  state_q <= (pace_cnt_q > 16'h0001) ? MLAIC_PACING : MLAIC_IDLE;
               end
            end
            MLAIC_PACING: begin
               if (pace_cnt_q <= 16'h0001) begin
                  state_q <= MLAIC_IDLE;
               end
            end
            default: begin
               state_q <= MLAIC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pace_cnt_q <= PACE_RESET;
      end else if (en_rise) begin
         pace_cnt_q <= PACE_RESET;
      end else if (state_q == MLAIC_IDLE && global_irq_enable && any_active) begin
         pace_cnt_q <= irq_pace_count_q;
      end else if (pace_cnt_q != PACE_RESET) begin
         pace_cnt_q <= pace_cnt_q - 16'h0001;
      end
   end

   // registered so the selector never sees a combinational glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else if (en_rise) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (state_q == MLAIC_IDLE || state_q == MLAIC_ASSERTED) &&
            global_irq_enable && any_active;
      end
   end
   assign irq_out = irq_q;

   // read decode, captured in the setup phase; pready is always high
   always_comb begin
      rdata_d = '0;
      err_d = 1'b0;
      if (paddr == OFS_WRAPPER_CONTROL) begin
         rdata_d[CTL_W-1:0] = wrapper_control_q;
      end else if (paddr == OFS_IRQ_PACE_COUNT) begin
         rdata_d[PACE_W-1:0] = irq_pace_count_q;
      end else if (paddr == OFS_TRANSFER_PRIORITY) begin
         rdata_d[PRIO_W-1:0] = prio_q;
      end else if (paddr == OFS_IRQ_CAUSE_VECTOR) begin
         rdata_d = irq_cause_vector;
      end else if (paddr == OFS_MONITOR_SELECT_SLOT0) begin
         rdata_d[SEL_W-1:0] = monitor_select_slot_q[0];
      end else if (paddr == OFS_MONITOR_SELECT_SLOT1) begin
         rdata_d[SEL_W-1:0] = monitor_select_slot_q[1];
      end else if (paddr == OFS_LINK_EVENT_RAW) begin
         rdata_d[NUM_SLOTS-1:0] = link_raw;
      end else if (paddr == OFS_LINK_EVENT_MASKED) begin
         rdata_d[NUM_SLOTS-1:0] = link_masked;
      end else if (paddr == OFS_COMPLETION_RAW) begin
         rdata_d[NUM_SLOTS-1:0] = comp_raw;
      end else if (paddr == OFS_COMPLETION_MASKED) begin
         rdata_d[NUM_SLOTS-1:0] = comp_masked;
      end else if (paddr == OFS_COMPLETION_MASK_SET || paddr == OFS_COMPLETION_MASK_CLEAR) begin
         rdata_d[NUM_SLOTS-1:0] = cmask_q;
      end else if (paddr == OFS_IRQ_STATE) begin
         rdata_d[STATE_IRQ_BIT] = irq_q;
         rdata_d[STATE_PACING_BIT] = (state_q == MLAIC_PACING);
         rdata_d[STATE_CNT_LSB +: PACE_W] = pace_cnt_q;
      end else begin
         err_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         err_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? '0 : rdata_d;
         err_q <= err_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & err_q;
endmodule : mlaic_combiner

// ---- testbench/mlaic_combiner_asserts.sv ----
// concurrent checks on the interrupt combiner ports
`timescale 1ns/10ps
module mlaic_combiner_asserts
   import mlaic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [PHY_COUNT-1:0] phy_link_status,
   input wire logic [NUM_SLOTS-1:0] access_go,
   input wire logic irq_out,
   input wire logic link_change_irq,
   input wire logic access_done_irq,
   input wire logic mac_reset,
   input wire logic mgmt_unit_reset,
   input wire logic [PRIO_W-1:0] transfer_priority_control
);
   logic wr, en_up, en_q, fresh_q, irq_d_q;
   logic [PACE_W-1:0] pace_q, load_q;
   logic [PACE_W:0] gap_q;
   logic [DATA_W-1:0] wd_q;
   assign wr = psel && penable && pwrite;
   assign en_up = wr && paddr == OFS_WRAPPER_CONTROL && pwdata[CTL_EN_BIT] && !en_q;
   // mirror of enable and pace count, rebuilt from bus writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         pace_q <= PACE_RESET;
         wd_q <= '0;
      end else begin
         wd_q <= pwdata;
         if (wr && paddr == OFS_WRAPPER_CONTROL) begin
            en_q <= pwdata[CTL_EN_BIT];
         end
         if (wr && paddr == OFS_IRQ_PACE_COUNT) begin
            pace_q <= pwdata[PACE_W-1:0];
         end
      end
   end
   // cycles since the last rise; saturates so a long idle never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_d_q <= 1'b0;
         gap_q <= 17'h10000;
         load_q <= PACE_RESET;
         fresh_q <= 1'b0;
      end else begin
         irq_d_q <= irq_out;
         if (irq_out && !irq_d_q) begin
            gap_q <= 17'h00001;
            load_q <= pace_q;
            fresh_q <= 1'b0;
         end else if (gap_q != 17'h10000) begin
            gap_q <= gap_q + 17'h00001;
         end
         if (en_up) begin
            fresh_q <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_reedge;
      !irq_out ##[1:2] irq_out;
   endsequence
   property p_ctl_fields;
      wr && paddr == OFS_WRAPPER_CONTROL |=>
         mac_reset == wd_q[CTL_MAC_RST_BIT] && mgmt_unit_reset == wd_q[CTL_MGMT_RST_BIT];
   endproperty
   a_ctl_fields: assert property (p_ctl_fields) else $error("reset bits differ");
   property p_prio;
      wr && paddr == OFS_TRANSFER_PRIORITY |=> transfer_priority_control == wd_q[PRIO_W-1:0];
   endproperty
   a_prio: assert property (p_prio) else $error("priority differs");
   property p_link_cause;
      $rose(link_change_irq) |-> $past(phy_link_status, 2) != $past(phy_link_status);
   endproperty
   a_link_cause: assert property (p_link_cause) else $error("link irq without change");
   property p_done_cause;
      $rose(access_done_irq) |-> |($past(access_go, 2) & ~$past(access_go));
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("done irq without fall");
   property p_link_level;
      link_change_irq && !mgmt_unit_reset && !(wr && (paddr == OFS_LINK_EVENT_RAW ||
         paddr == OFS_LINK_EVENT_MASKED || paddr == OFS_WRAPPER_CONTROL)) |=> link_change_irq;
   endproperty
   a_link_level: assert property (p_link_level) else $error("link irq dropped");
   property p_mgmt_hold;
      mgmt_unit_reset && $past(mgmt_unit_reset) |-> !link_change_irq && !access_done_irq;
   endproperty
   a_mgmt_hold: assert property (p_mgmt_hold) else $error("irq during reset");
   property p_reedge;
      en_up && !pwdata[CTL_MGMT_RST_BIT] && (link_change_irq || access_done_irq) |=> s_reedge;
   endproperty
   a_reedge: assert property (p_reedge) else $error("no new edge");
   property p_pace;
      $rose(irq_out) && !fresh_q |-> gap_q + 17'h00001 >= {1'b0, load_q};
   endproperty
   a_pace: assert property (p_pace) else $error("edge inside pace window");
endmodule : mlaic_combiner_asserts

bind mlaic_combiner mlaic_combiner_asserts i_mlaic_combiner_asserts (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .phy_link_status,
   .access_go, .irq_out, .link_change_irq, .access_done_irq, .mac_reset,
   .mgmt_unit_reset, .transfer_priority_control
);

// ---- testbench/mlaic_irq_sel_model.sv ----
// interrupt selector model: counts routed rising edges and their cycle
`timescale 1ns/10ps
module mlaic_irq_sel_model
   import mlaic_pkg::*;
#(
   parameter logic [4:0] PERIPH_CODE = 5'h18
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic irq_out,
   input wire logic [4:0] sel_code,
   output logic [15:0] edge_count,
   output logic [31:0] edge_cycle
);
   logic irq_d_q;
   logic [31:0] cyc_q;
   // the core only sees edges, so a held level raises nothing new
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_d_q <= 1'b0;
         cyc_q <= 32'h0;
         edge_count <= 16'h0;
         edge_cycle <= 32'h0;
      end else begin
         irq_d_q <= irq_out;
         cyc_q <= cyc_q + 32'h1;
         if (irq_out && !irq_d_q && sel_code == PERIPH_CODE) begin
            edge_count <= edge_count + 16'h1;
            edge_cycle <= cyc_q;
         end
      end
   end
endmodule : mlaic_irq_sel_model

// ---- testbench/mlaic_combiner_tb_top.sv ----
// self-checking bench for the interrupt combiner
`timescale 1ns/10ps
`define CHK(got, exp) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); \
   end \
end
module mlaic_combiner_tb_top
   import mlaic_pkg::*;
();
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rdat;
   logic pready, pslverr, rerr, irq_out, link_change_irq, access_done_irq;
   logic mac_reset, mgmt_unit_reset;
   logic [PRIO_W-1:0] transfer_priority_control;
   logic [TX_CH-1:0] tx_channel_pending = '0;
   logic [RX_CH-1:0] rx_channel_pending = '0;
   logic statistics_pending = 1'b0, host_error_pending = 1'b0;
   logic [PHY_COUNT-1:0] phy_link_status = '0;
   logic [NUM_SLOTS-1:0] access_go = '0;
   logic [15:0] edge_count;
   logic [31:0] edge_cycle, t0;
   int failures = 0, samples_checked = 0;
   mlaic_combiner i_mlaic_combiner (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tx_channel_pending, .rx_channel_pending,
      .statistics_pending, .host_error_pending, .phy_link_status, .access_go, .irq_out,
      .link_change_irq, .access_done_irq, .mac_reset, .mgmt_unit_reset,
      .transfer_priority_control);
   mlaic_irq_sel_model i_mlaic_irq_sel_model (.pclk, .presetn, .irq_out,
      .sel_code(5'h18), .edge_count, .edge_cycle);
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   // one transfer; an idle cycle follows so psel is never re-driven in one step
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         @(posedge pclk);
         k++;
      end
      if (k == 50) begin
         failures++;
         end_of_test();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask : rd
   task automatic pulse(input logic [NUM_SLOTS-1:0] s);
      access_go <= s;
      tick(2);
      access_go <= 2'b00;
      tick(3);
   endtask : pulse
   task automatic wait_edges(input logic [15:0] n, input int lim);
      int k;
      k = 0;
      while (edge_count !== n && k < lim) begin
         @(posedge pclk);
         k++;
      end
      `CHK(edge_count, n)
   endtask : wait_edges
   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      end_of_test();
   end
   initial begin
      tick(16);
      presetn <= 1'b1;
      tick(1);
      rd(OFS_WRAPPER_CONTROL, 32'h0);
      rd(OFS_IRQ_PACE_COUNT, 32'h0);
      rd(OFS_IRQ_STATE, 32'h0);
      rd(8'h40, 32'h0);
      `CHK(rerr, 1'b1)
      wr(OFS_WRAPPER_CONTROL, 32'h6);
      `CHK({mgmt_unit_reset, mac_reset}, 2'b11)
      wr(OFS_TRANSFER_PRIORITY, 32'h13);
      `CHK(transfer_priority_control, 8'h13)
      tx_channel_pending <= 8'hA5;
      rx_channel_pending <= 8'h3C;
      statistics_pending <= 1'b1;
      host_error_pending <= 1'b1;
      wr(OFS_WRAPPER_CONTROL, 32'h3);
      rd(OFS_IRQ_CAUSE_VECTOR, 32'h0);
      `CHK(irq_out, 1'b0)
      wr(OFS_WRAPPER_CONTROL, 32'h1);
      rd(OFS_IRQ_CAUSE_VECTOR, 32'h0003_3CA5);
      wait_edges(16'h1, 10);
      wr(OFS_WRAPPER_CONTROL, 32'h0);
      tx_channel_pending <= 8'h00;
      rx_channel_pending <= 8'h00;
      statistics_pending <= 1'b0;
      host_error_pending <= 1'b0;
      // slot 1 watches a changing phy but has its link enable off
      wr(OFS_MONITOR_SELECT_SLOT0, 32'h105);
      wr(OFS_MONITOR_SELECT_SLOT1, 32'h009);
      phy_link_status <= 32'h0000_0220;
      tick(3);
      rd(OFS_LINK_EVENT_RAW, 32'h3);
      rd(OFS_LINK_EVENT_MASKED, 32'h1);
      rd(OFS_IRQ_CAUSE_VECTOR, 32'h0004_0000);
      wr(OFS_WRAPPER_CONTROL, 32'h1);
      wait_edges(16'h2, 10);
      // disable then re-enable with the link event still pending must raise a new edge
      wr(OFS_WRAPPER_CONTROL, 32'h0);
      wr(OFS_WRAPPER_CONTROL, 32'h1);
      wait_edges(16'h3, 10);
      wr(OFS_LINK_EVENT_MASKED, 32'h1);
      `CHK(link_change_irq, 1'b0)
      rd(OFS_LINK_EVENT_RAW, 32'h2);
      wr(OFS_LINK_EVENT_RAW, 32'h2);
      rd(OFS_LINK_EVENT_RAW, 32'h0);
      wr(OFS_COMPLETION_MASK_SET, 32'h1);
      rd(OFS_COMPLETION_MASK_CLEAR, 32'h1);
      pulse(2'b11);
      rd(OFS_COMPLETION_RAW, 32'h3);
      rd(OFS_COMPLETION_MASKED, 32'h1);
      wait_edges(16'h4, 10);
      tick(20);
      `CHK(access_done_irq, 1'b1)
      wr(OFS_COMPLETION_MASKED, 32'h1);
      rd(OFS_COMPLETION_RAW, 32'h2);
      `CHK(access_done_irq, 1'b0)
      // a second completion soon after an edge must wait out the pace count
      wr(OFS_IRQ_PACE_COUNT, 32'h14);
      pulse(2'b01);
      wait_edges(16'h5, 10);
      t0 = edge_cycle;
      wr(OFS_COMPLETION_MASKED, 32'h1);
      pulse(2'b01);
      wait_edges(16'h6, 40);
      `CHK(edge_cycle - t0 >= 32'h13 && edge_cycle - t0 <= 32'h16, 1'b1)
      wr(OFS_IRQ_PACE_COUNT, 32'hC8);
      wr(OFS_COMPLETION_MASKED, 32'h1);
      pulse(2'b01);
      wait_edges(16'h7, 30);
      wr(OFS_COMPLETION_MASKED, 32'h1);
      pulse(2'b01);
      tick(10);
      `CHK(edge_count, 16'h7)
      wr(OFS_WRAPPER_CONTROL, 32'h0);
      wr(OFS_WRAPPER_CONTROL, 32'h1);
      wait_edges(16'h8, 6);
      phy_link_status <= 32'h0000_0200;
      tick(3);
      `CHK(link_change_irq, 1'b1)
      wr(OFS_WRAPPER_CONTROL, 32'h4);
      // the slots clear on the edge after the reset bit lands
      tick(1);
      `CHK({link_change_irq, access_done_irq}, 2'b00)
      phy_link_status <= 32'h0000_0220;
      tick(3);
      rd(OFS_LINK_EVENT_RAW, 32'h0);
      wr(OFS_WRAPPER_CONTROL, 32'h0);
      rd(OFS_LINK_EVENT_RAW, 32'h0);
      wr(OFS_COMPLETION_MASK_CLEAR, 32'h1);
      rd(OFS_COMPLETION_MASK_SET, 32'h0);
      end_of_test();
   end
endmodule : mlaic_combiner_tb_top
